// ===== bench/sffs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sffs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // config
  input wire logic cfg_we,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic [2:0] first_avg,
  input wire logic [2:0] second_avg,
  // samples, enables, fifo
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic sample_second,
  input wire logic first_slot_enable,
  input wire logic second_slot_enable,
  input wire logic fifo_valid,
  input wire logic fifo_ready,
  input wire logic [15:0] fifo_data,
  input wire logic second_blocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // quiet: settled config, idle intake and nothing queued, so a take
  // stands alone and any later word can only come from it
  sequence s_quiet;
    (!cfg_we && !fifo_valid && sample_ready)[*3];
  endsequence
  sequence s_take; sample_valid && sample_ready; endsequence
  property p_rdata;
    cfg_we |-> ##2 cfg_rdata == ($past(cfg_wdata, 2) & 16'h01fd);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("config readback");
  property p_en1;
    cfg_we |-> ##2 first_slot_enable == $past(cfg_wdata[0], 2);
  endproperty
  a_en1: assert property (p_en1)
    else $error("first enable");
  property p_en2;
    cfg_we |-> ##2 second_slot_enable == $past(cfg_wdata[5], 2);
  endproperty
  a_en2: assert property (p_en2)
    else $error("second enable");
  property p_blk;
    (!cfg_we)[*3] ##0 ($stable(first_avg) && $stable(second_avg)) |->
      second_blocked == (cfg_rdata[8:6] != 3'h0 && cfg_rdata[4:2] != 3'h0
      && first_avg != second_avg);
  endproperty
  a_blk: assert property (p_blk)
    else $error("second blocked");
  property p_hold;
    fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("fifo word lost");
  property p_drop1;
    s_quiet ##0 (s_take ##0 (!sample_second && (!first_slot_enable ||
      cfg_rdata[4:2] inside {3'h0, 3'h3, 3'h5, 3'h7}))) |=> !fifo_valid[*3];
  endproperty
  a_drop1: assert property (p_drop1)
    else $error("first slot stored");
  property p_drop2;
    s_quiet ##0 (s_take ##0 (sample_second && (!second_slot_enable ||
      cfg_rdata[8:6] == 3'h0 || second_blocked))) |=> !fifo_valid[*3];
  endproperty
  a_drop2: assert property (p_drop2)
    else $error("second slot stored");
  property p_sum16;
    s_quiet ##0 (s_take ##0 (!sample_second && first_slot_enable &&
      cfg_rdata[4:2] == 3'h1)) |-> ##[1:3] fifo_valid;
  endproperty
  a_sum16: assert property (p_sum16)
    else $error("sum word missing");
endmodule
bind sffs_top sffs_chk chk (.clk(clk), .rstn(rstn), .cfg_we(cfg_we),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .first_avg(first_avg),
  .second_avg(second_avg), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .sample_second(sample_second),
  .first_slot_enable(first_slot_enable), .fifo_data(fifo_data),
  .second_slot_enable(second_slot_enable), .fifo_valid(fifo_valid),
  .fifo_ready(fifo_ready), .second_blocked(second_blocked));
`default_nettype wire

// ===== bench/sffs_host.sv
`timescale 1ns/1ps
`default_nettype none
module sffs_host (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fifo read side
  input wire logic fifo_valid,
  output logic fifo_ready,
  input wire logic [15:0] fifo_data,
  // bench control: stall models a slow host
  input wire logic stall
);
  logic [15:0] rx[$];
  // words kept in arrival order so the bench can judge ordering
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fifo_ready <= 1'b0;
    end else begin
      if (fifo_valid && fifo_ready) rx.push_back(fifo_data);
      fifo_ready <= !stall;
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sffs_pkg::*;
  logic clk, rstn, cfg_we, sample_valid, sample_second, fifo_ready, stall;
  logic [15:0] cfg_wdata, cfg_rdata, fifo_data;
  logic [2:0] first_avg, second_avg;
  logic [127:0] sample_data;
  logic sample_ready, first_slot_enable, second_slot_enable, fifo_valid;
  logic second_blocked;
  logic [15:0] exp_q[$];
  int failures, tests_run;
  sffs_top dut (.clk(clk), .rstn(rstn), .cfg_we(cfg_we),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .first_avg(first_avg),
    .second_avg(second_avg),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_second(sample_second), .sample_data(sample_data),
    .first_slot_enable(first_slot_enable), .fifo_valid(fifo_valid),
    .second_slot_enable(second_slot_enable), .fifo_ready(fifo_ready),
    .fifo_data(fifo_data), .second_blocked(second_blocked));
  sffs_host host (.clk(clk), .rstn(rstn), .fifo_valid(fifo_valid),
    .fifo_ready(fifo_ready), .fifo_data(fifo_data), .stall(stall));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wcfg(input logic [15:0] v);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_we <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // code is what the bench expects stored; 0 means dropped
  task automatic send(input logic sec, input logic [2:0] code);
    logic [31:0] ch[4];
    logic [31:0] sum;
    int n;
    sum = 32'h0;
    for (int i = 0; i < 4; i++) begin
      ch[i] = 32'h9357_9bdf * (i + (sec ? 7 : 3)); // slots carry own data
      sum += ch[i];
    end
    if (code == 3'h1 || code == 3'h2) exp_q.push_back(sum[15:0]);
    if (code == 3'h2) exp_q.push_back(sum[31:16]);
    for (int i = 0; i < 4; i++) begin
      if (code[2]) exp_q.push_back(ch[i][15:0]);
      if (code == 3'h6) exp_q.push_back(ch[i][31:16]);
    end
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_second <= sec;
    sample_data <= {ch[3], ch[2], ch[1], ch[0]};
    // ready only moves on rising edges, so the falling edge sees its value
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!sample_ready && n < 300);
    if (!sample_ready) begin
      failures++;
      $display("MISMATCH t=%0t sample intake timed out", $time);
      results();
    end
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (host.rx.size() < exp_q.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    chk(16'(host.rx.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < host.rx.size()) chk(host.rx[i], exp_q[i]);
    end
    if (n == 400) begin
      failures++;
      $display("MISMATCH t=%0t host drain timed out", $time);
      results();
    end
    host.rx.delete();
    exp_q.delete();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reg;
    wcfg(16'hffff);
    chk(cfg_rdata, 16'h01fd);
    chk(16'({first_slot_enable, second_slot_enable}), 16'h3);
    wcfg(16'h0000);
    chk(16'({first_slot_enable, second_slot_enable}), 16'h0);
  endtask
  // every stored code on both slots; the 8-word case overfills the buffer
  task automatic t_formats;
    logic [2:0] codes[4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    for (int s = 0; s < 2; s++) begin
      foreach (codes[i]) begin
        wcfg(s ? 16'h0020 | 16'(codes[i]) << 6
               : 16'h0001 | 16'(codes[i]) << 2);
        stall <= (codes[i] == 3'h6);
        send(s[0], codes[i]);
        repeat (20) @(posedge clk);
        if (codes[i] == 3'h6) chk(16'(sample_ready), 16'h0);
        stall <= 1'b0;
        drain();
      end
    end
  endtask
  task automatic t_pair;
    wcfg(16'h0065);
    send(1'b0, 3'h1);
    send(1'b1, 3'h1);
    drain();
    second_avg <= 3'h3;
    wcfg(16'h0065);
    chk(16'(second_blocked), 16'h1);
    send(1'b0, 3'h1);
    send(1'b1, 3'h0);
    drain();
    wcfg(16'h0061);
    chk(16'(second_blocked), 16'h0);
    send(1'b0, 3'h0);
    send(1'b1, 3'h1);
    drain();
    wcfg(16'h004d);
    send(1'b0, 3'h0);
    send(1'b1, 3'h0);
    drain();
  endtask
  initial begin
    rstn = 1'b0;
    cfg_we = 1'b0;
    cfg_wdata = 16'h0000;
    first_avg = 3'h2;
    second_avg = 3'h2;
    sample_valid = 1'b0;
    sample_second = 1'b0;
    sample_data = 128'h0;
    stall = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reg();
    t_formats();
    t_pair();
    results();
  end
endmodule
`default_nettype wire

// ===== inc/sffs_pkg.sv
package sffs_pkg;
  // ---------------------------------------------------------------
  // config register layout
  // ---------------------------------------------------------------
  localparam int CFG_W = 16;
  localparam int FIRST_EN_BIT = 0;
  localparam int FIRST_FMT_LO = 2;
  localparam int SECOND_EN_BIT = 5;
  localparam int SECOND_FMT_LO = 6;
  localparam int FMT_W = 3;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WMASK = 16'h01fd; // bits 15..9 and 1 reserved
  // ---------------------------------------------------------------
  // format codes
  // ---------------------------------------------------------------
  localparam logic [2:0] FMT_NONE = 3'h0;
  localparam logic [2:0] FMT_SUM16 = 3'h1;
  localparam logic [2:0] FMT_SUM32 = 3'h2;
  localparam logic [2:0] FMT_CH16 = 3'h4;
  localparam logic [2:0] FMT_CH32 = 3'h6;
  // ---------------------------------------------------------------
  // data path sizes
  // ---------------------------------------------------------------
  localparam int CH_W = 32;
  localparam int NUM_CH = 4;
  localparam int AVG_W = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W = 16;
endpackage

// ===== verilog/sffs_top.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// small word fifo, ring buffer with a fill counter
// ---------------------------------------------------------------
// a fill counter instead of a spare pointer bit keeps full and empty to
// one compare each; the read side is combinational, so the user must
// register it before it leaves the block
module sffs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // full and empty both come straight from the fill counter
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  // no reset here: an entry is only read after it has been written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  // pointers wrap by compare, so a depth that is not a power of two works
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ---------------------------------------------------------------
// slot formatter: turns one sample period into fifo words
// ---------------------------------------------------------------
// results arrive one slot at a time; each stored result is expanded
// into one to eight 16-bit words and queued for the host in order
module sffs_top
  import sffs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // config register port
  input wire logic cfg_we,
  input wire logic [CFG_W-1:0] cfg_wdata,
  output logic [CFG_W-1:0] cfg_rdata,
  // averaging factors from the timing core
  input wire logic [AVG_W-1:0] first_avg,
  input wire logic [AVG_W-1:0] second_avg,
  // sample input, one pulse per slot result
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic sample_second,
  input wire logic [NUM_CH*CH_W-1:0] sample_data,
  // slot enables to the timing core
  output logic first_slot_enable,
  output logic second_slot_enable,
  // host fifo read side
  output logic fifo_valid,
  input wire logic fifo_ready,
  output logic [WORD_W-1:0] fifo_data,
  // status
  output logic second_blocked
);
  // two states are enough: the word index carries the rest of the walk
  typedef enum logic [1:0] {SFFS_IDLE, SFFS_EMIT} sffs_state_t;

  logic [CFG_W-1:0] cfg;
  logic [FMT_W-1:0] first_fifo_format;
  logic [FMT_W-1:0] second_fifo_format;
  logic second_ok;
  sffs_state_t state;
  logic [FMT_W-1:0] fmt;
  logic [NUM_CH*CH_W-1:0] hold;
  logic [3:0] idx;
  logic [3:0] last_idx;
  logic [CH_W-1:0] sum;
  logic [CH_W-1:0] cur32;
  logic [WORD_W-1:0] word;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic [WORD_W-1:0] f_out_data;
  logic take;
  logic [FMT_W-1:0] next_fmt;

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  // one config word; reserved bits are masked on write so that readback
  // never shows what the host put into them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= CFG_RESET;
    end else if (cfg_we) begin
      cfg <= cfg_wdata & CFG_WMASK; // reserved bits stay zero
    end
  end
  assign first_fifo_format = cfg[FIRST_FMT_LO +: FMT_W];
  assign second_fifo_format = cfg[SECOND_FMT_LO +: FMT_W];

  // second slot may only store under matching averaging or when first_fifo_format is FMT_NONE
  // a mismatch matters whenever first_fifo_format is not FMT_NONE, even with the first slot disabled;
  // averaging is a live input, so the check follows it every cycle
  assign second_ok = (first_avg == second_avg) ||
                     (first_fifo_format == FMT_NONE);

  // registered outputs: readback, enables, status
  // readback trails the register by one cycle, like the enables, and
  // the status flag tells the host its second-slot setting is ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= '0;
      first_slot_enable <= 1'b0;
      second_slot_enable <= 1'b0;
      second_blocked <= 1'b0;
    end else begin
      cfg_rdata <= cfg;
      first_slot_enable <= cfg[FIRST_EN_BIT];
      second_slot_enable <= cfg[SECOND_EN_BIT];
      second_blocked <= !second_ok && (second_fifo_format != FMT_NONE);
    end
  end

  // ---------------------------------------------------------------
  // sample intake: pick the format for this slot result
  // ---------------------------------------------------------------
  // reserved codes are dropped rather than guessed at, and a disabled
  // slot stores nothing even if its format field is set; next_fmt is
  // the format this result would use if it were taken now
  always_comb begin
    next_fmt = sample_second ? second_fifo_format : first_fifo_format;
    if (sample_second && (!second_ok || !cfg[SECOND_EN_BIT])) begin
      next_fmt = FMT_NONE;
    end else if (!sample_second && !cfg[FIRST_EN_BIT]) begin
      next_fmt = FMT_NONE;
    end
    case (next_fmt)
      FMT_SUM16, FMT_SUM32, FMT_CH16, FMT_CH32: begin
      end
      default: begin
        next_fmt = FMT_NONE;
      end
    endcase
  end

  // one slot at a time: results arrive in slot order, so the first
  // slot's words are fully queued before the second slot's start;
  // ready is a flop in the sequencer that mirrors the idle state, so
  // the source sees a registered handshake
  assign take = sample_valid && sample_ready;

  // word count per format, minus one
  // the longest case is eight words, so a 4-bit index leaves headroom
  always_comb begin
    case (fmt)
      FMT_SUM16: last_idx = 4'd0;
      FMT_SUM32: last_idx = 4'd1;
      FMT_CH16: last_idx = 4'd3;
      FMT_CH32: last_idx = 4'd7;
      default: last_idx = 4'd0;
    endcase
  end

  // sequencer: idle waits for a storable result, emit pushes one word
  // per cycle that the fifo accepts; a full fifo just stalls emit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= SFFS_IDLE;
      sample_ready <= 1'b1;
      fmt <= FMT_NONE;
      hold <= '0;
      idx <= '0;
    end else begin
      case (state)
        SFFS_IDLE: begin
          if (take && next_fmt != FMT_NONE) begin
            state <= SFFS_EMIT;
            sample_ready <= 1'b0;
            fmt <= next_fmt;
            hold <= sample_data;
            idx <= '0;
          end
        end
        SFFS_EMIT: begin
          if (f_in_ready) begin
            if (idx == last_idx) begin
              state <= SFFS_IDLE;
              sample_ready <= 1'b1;
            end else begin
              idx <= idx + 4'd1;
            end
          end
        end
        default: begin
          state <= SFFS_IDLE;
          sample_ready <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // word selection
  // ---------------------------------------------------------------
  // four-channel sum; low 16 bits only are kept for the short form
  // hold is captured at take, so sample_data may move while words go out;
  // the 32-bit sum wraps on overflow like a plain adder
  assign sum = hold[0 +: CH_W] + hold[CH_W +: CH_W] +
               hold[2*CH_W +: CH_W] + hold[3*CH_W +: CH_W];
  assign cur32 = hold[idx[2:1]*CH_W +: CH_W];

  // 32-bit values go out low half first; 16-bit channel words are the
  // low half of each channel
  always_comb begin
    case (fmt)
      FMT_SUM16: word = sum[WORD_W-1:0];
      FMT_SUM32: word = idx[0] ? sum[CH_W-1:WORD_W]
                               : sum[WORD_W-1:0];
      FMT_CH16: word = hold[idx[1:0]*CH_W +: WORD_W];
      FMT_CH32: word = idx[0] ? cur32[CH_W-1:WORD_W]
                              : cur32[WORD_W-1:0];
      default: word = '0;
    endcase
  end
  // every emit cycle offers a word; the fifo's ready paces the index
  assign f_in_valid = (state == SFFS_EMIT);

  // ---------------------------------------------------------------
  // output fifo and host-facing register stage
  // ---------------------------------------------------------------
  sffs_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(word),
    .out_valid(f_out_valid),
    .out_ready(!fifo_valid || fifo_ready),
    .out_data(f_out_data)
  );

  // skid-free output register keeps host outputs flop-driven; it takes
  // a word whenever it is empty or its word is taken, so the host sees
  // one extra word of buffering
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fifo_valid <= 1'b0;
      fifo_data <= '0;
    end else if (!fifo_valid || fifo_ready) begin
      fifo_valid <= f_out_valid;
      if (f_out_valid) begin
        fifo_data <= f_out_data;
      end
    end
  end
endmodule

`default_nettype wire
